//--- src/host_interrupt_mask_gating.sv
// Host interrupt enable mask with set/clear access and interrupt gating.
// Assumes event bits come from logic on sys_clk and a one-cycle strobe bus.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Reads at set or clear address return the same mask contents.
// - Mask is at 88h for set and 8Ch for clear.
// - Bit 31 zero blocks every external interrupt.
// - Enables other than 31, 7 and 6 align with event bits.
// - Enable 30 with maker-defined event 30 requests interrupt.
// - Enable 29 with software-raised event 29 requests interrupt.
// - Bit 28 is reserved and reads zero.
// - Bits 14 to 10 are reserved and read zero.
// - Enables 27 and 26 gate their matching events.
// - Enables 25 and 24 gate their matching events.
// - Enables 23 and 22 gate their matching events.
// - Enables 21 and 20 gate their matching events.
// - Enables 19 and 18 gate their matching events.
// - Enables 17, 16 and 15 gate their matching events.
// - Enables 9 and 8 gate their matching events.
// - Enables 7 and 6 gate the iso RX and TX summaries.
// - Enables 5 and 4 gate their matching events.
// - Enables 3 and 2 gate their matching events.
// - Enables 1 and 0 gate their matching events.
// - Iso event bits are OR of per-context event AND mask.
module host_interrupt_mask_gating (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [irq_mask_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irq_mask_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [irq_mask_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [irq_mask_pkg::DATA_W-1:0] event_bits,
  input wire logic [irq_mask_pkg::ISO_CTX-1:0] iso_tx_ctx_event,
  input wire logic [irq_mask_pkg::ISO_CTX-1:0] iso_rx_ctx_event,
  output logic irq_out
);
  import irq_mask_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Address decode.

  function automatic acc_t decode(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] set_ofs,
                                  input logic [ADDR_W-1:0] clr_ofs);
    acc_t r;
    r = ACC_NONE;
    if (a == set_ofs)
    begin
      r = ACC_SET;
    end
    else if (a == clr_ofs)
    begin
      r = ACC_CLR;
    end
    return r;
  endfunction

  acc_t main_acc;
  acc_t tx_acc;
  acc_t rx_acc;

  assign main_acc = decode(reg_addr, OFS_MASK_SET, OFS_MASK_CLR);
  assign tx_acc = decode(reg_addr, OFS_ISO_TX_MASK_SET, OFS_ISO_TX_MASK_CLR);
  assign rx_acc = decode(reg_addr, OFS_ISO_RX_MASK_SET, OFS_ISO_RX_MASK_CLR);

  ////////////////////////////////////////////////////////////////////////
  // Mask storage; one store behind both addresses.

  logic [DATA_W-1:0] enable_mask;
  logic [ISO_CTX-1:0] iso_tx_mask;
  logic [ISO_CTX-1:0] iso_rx_mask;

  // Reserved bits are never stored and reset bits load zero.
  setclr_reg #(
    .W(DATA_W),
    .IMPL(MASK_IMPL),
    .RST(MASK_RST & ~MASK_RST_ZERO)
  ) u_mask (
    .sys_clk(sys_clk),
    .reset(reset),
    .set_en(reg_wr && main_acc == ACC_SET),
    .clr_en(reg_wr && main_acc == ACC_CLR),
    .wdata(reg_wdata),
    .value(enable_mask)
  );

  setclr_reg #(
    .W(ISO_CTX),
    .IMPL('1),
    .RST(ISO_MASK_RST)
  ) u_tx_mask (
    .sys_clk(sys_clk),
    .reset(reset),
    .set_en(reg_wr && tx_acc == ACC_SET),
    .clr_en(reg_wr && tx_acc == ACC_CLR),
    .wdata(reg_wdata[ISO_CTX-1:0]),
    .value(iso_tx_mask)
  );

  setclr_reg #(
    .W(ISO_CTX),
    .IMPL('1),
    .RST(ISO_MASK_RST)
  ) u_rx_mask (
    .sys_clk(sys_clk),
    .reset(reset),
    .set_en(reg_wr && rx_acc == ACC_SET),
    .clr_en(reg_wr && rx_acc == ACC_CLR),
    .wdata(reg_wdata[ISO_CTX-1:0]),
    .value(iso_rx_mask)
  );

  ////////////////////////////////////////////////////////////////////////
  // Isochronous summaries replace the event inputs at bits 7 and 6.

  logic iso_tx_sum;
  logic iso_rx_sum;

  iso_ctx_or #(.N(ISO_CTX)) u_tx_or (
    .ctx_event(iso_tx_ctx_event),
    .ctx_mask(iso_tx_mask),
    .summary(iso_tx_sum)
  );

  iso_ctx_or #(.N(ISO_CTX)) u_rx_or (
    .ctx_event(iso_rx_ctx_event),
    .ctx_mask(iso_rx_mask),
    .summary(iso_rx_sum)
  );

  logic [DATA_W-1:0] events_eff;
  logic [DATA_W-1:0] pending;

  always_comb
  begin
    events_eff = event_bits;
    events_eff[BIT_GLOBAL_GATE] = 1'b0;
    events_eff[BIT_ISO_RX] = iso_rx_sum;
    events_eff[BIT_ISO_TX] = iso_tx_sum;
  end

  // Bit-for-bit gating covers 30, 29 and every aligned source.
  assign pending = events_eff & enable_mask & MASK_IMPL;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt output, registered for a clean pin.

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= enable_mask[BIT_GLOBAL_GATE] && (|pending);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port.

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      reg_rdata <= UNMAPPED_READ;
    end
    else if (reg_rd)
    begin
      if (main_acc != ACC_NONE)
      begin
        reg_rdata <= enable_mask;
      end
      else if (tx_acc != ACC_NONE)
      begin
        reg_rdata <= {{(DATA_W-ISO_CTX){1'b0}}, iso_tx_mask};
      end
      else if (rx_acc != ACC_NONE)
      begin
        reg_rdata <= {{(DATA_W-ISO_CTX){1'b0}}, iso_rx_mask};
      end
      else if (reg_addr == OFS_PENDING)
      begin
        reg_rdata <= pending;
      end
      else
      begin
        reg_rdata <= UNMAPPED_READ;
      end
    end
    else
    begin
      reg_rdata <= UNMAPPED_READ;
    end
  end

endmodule

//--- src/irq_mask_pkg.sv
// Constants for the host interrupt enable mask block.
// Assumes a 32-bit register port with read data one cycle after the strobe.
package irq_mask_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ISO_CTX = 8;

  localparam logic [ADDR_W-1:0] OFS_MASK_SET = 8'h88;
  localparam logic [ADDR_W-1:0] OFS_MASK_CLR = 8'h8C;
  localparam logic [ADDR_W-1:0] OFS_ISO_TX_MASK_SET = 8'h98;
  localparam logic [ADDR_W-1:0] OFS_ISO_TX_MASK_CLR = 8'h9C;
  localparam logic [ADDR_W-1:0] OFS_ISO_RX_MASK_SET = 8'hA8;
  localparam logic [ADDR_W-1:0] OFS_ISO_RX_MASK_CLR = 8'hAC;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 8'hB0;

  localparam int BIT_GLOBAL_GATE = 31;
  localparam int BIT_MAKER_SRC = 30;
  localparam int BIT_SOFT_SRC = 29;
  localparam int BIT_ISO_RX = 7;
  localparam int BIT_ISO_TX = 6;

  // Bits that exist in the mask; 28 and 14..10 are reserved.
  localparam logic [DATA_W-1:0] MASK_IMPL = 32'hEFFF_83FF;
  // Bits given a defined zero at reset.
  localparam logic [DATA_W-1:0] MASK_RST_ZERO = 32'h3804_7C00;
  // Undefined reset bits are loaded with zero as well.
  localparam logic [DATA_W-1:0] MASK_RST = 32'h0000_0000;
  localparam logic [ISO_CTX-1:0] ISO_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [2:0] {
    ACC_NONE = 3'b001,
    ACC_SET = 3'b010,
    ACC_CLR = 3'b100
  } acc_t;

endpackage

//--- src/setclr_reg.sv
// Set/clear register: ones written at the set port set bits, ones at the
// clear port clear them. Assumes at most one of set/clear per cycle.
`timescale 1ns/1ps
module setclr_reg #(
  parameter int W = 32,
  parameter logic [W-1:0] IMPL = '1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic set_en,
  input wire logic clr_en,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] value
);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      value <= RST & IMPL;
    end
    else if (set_en)
    begin
      value <= (value | wdata) & IMPL;
    end
    else if (clr_en)
    begin
      value <= value & ~wdata & IMPL;
    end
  end

endmodule

//--- src/iso_ctx_or.sv
// Per-context gating of isochronous events into one summary bit.
// Assumes events are already on sys_clk.
`timescale 1ns/1ps
module iso_ctx_or #(
  parameter int N = 8
) (
  input wire logic [N-1:0] ctx_event,
  input wire logic [N-1:0] ctx_mask,
  output logic summary
);

  assign summary = |(ctx_event & ctx_mask);

endmodule

//--- verification/host_interrupt_mask_gating_asserts.sv
// Assertions on the host interrupt enable mask block.
// Assumes a bind to the top module; sees only its ports.
`timescale 1ns/1ps
module irq_mask_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [irq_mask_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irq_mask_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [irq_mask_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [irq_mask_pkg::DATA_W-1:0] event_bits,
  input wire logic irq_out
);
  import irq_mask_pkg::*;
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] gated;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      mask_r <= '0;
    else if (reg_wr && reg_addr == OFS_MASK_SET)
      mask_r <= mask_r | (reg_wdata & MASK_IMPL);
    else if (reg_wr && reg_addr == OFS_MASK_CLR)
      mask_r <= mask_r & ~reg_wdata;
  end
  // Bits 7 and 6 come from the iso contexts, so they are left out.
  assign gated = event_bits & mask_r & 32'h7FFF_FF3F;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_rd_mask;
    reg_rd && (reg_addr == OFS_MASK_SET || reg_addr == OFS_MASK_CLR);
  endsequence
  ////////////////////////
  a_read_mask:
    assert property (s_rd_mask |=> reg_rdata == $past(mask_r))
    else $error("Mask read wrong.");
  a_resv_high:
    assert property (reg_rd |=> !reg_rdata[28])
    else $error("Bit 28 set.");
  a_resv_low:
    assert property (reg_rd |=> reg_rdata[14:10] == 5'h00)
    else $error("Bits 14 to 10 set.");
  a_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == '0)
    else $error("Stray read data.");
  a_unmapped_zero:
    assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == '0)
    else $error("Unmapped read nonzero.");
  a_irq_on:
    assert property (mask_r[31] && |gated |=> irq_out)
    else $error("Missing interrupt.");
  a_irq_off:
    assert property (!mask_r[31] |=> !irq_out)
    else $error("Interrupt while gated.");
  a_reset_quiet:
    assert property (disable iff (1'b0) reset |=> !irq_out && !reg_rdata)
    else $error("Outputs busy after reset.");
endmodule
bind host_interrupt_mask_gating irq_mask_checker chk (.sys_clk, .reset,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .event_bits, .irq_out);

//--- verification/tb_host_interrupt_mask_gating.sv
// Testbench for the host interrupt enable mask block.
// Assumes the checker file binds itself to the design.
`timescale 1ns/1ps
module tb_host_interrupt_mask_gating;
  import irq_mask_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] event_bits = '0;
  logic [ISO_CTX-1:0] iso_tx_ctx_event = '0;
  logic [ISO_CTX-1:0] iso_rx_ctx_event = '0;
  logic irq_out;
  logic rd_d = 1'b0;
  logic [DATA_W-1:0] m = '0;
  logic [DATA_W-1:0] b;
  logic [DATA_W-1:0] exp_q[$];
  int bad_count = 0;
  int checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  host_interrupt_mask_gating dut (.sys_clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .event_bits, .iso_tx_ctx_event,
    .iso_rx_ctx_event, .irq_out);
  task automatic chk(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One bus cycle; a read queues the value it should return.
  task automatic acc(int w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= (w != 0);
    reg_rd <= (w == 0);
    if (w == 0)
      exp_q.push_back(d);
    else if (a == OFS_MASK_SET)
      m = m | (d & MASK_IMPL);
    else if (a == OFS_MASK_CLR)
      m = m & ~d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic irq_is(logic [DATA_W-1:0] ev, logic e);
    event_bits <= ev;
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, irq_out}, {31'h0, e});
    @(posedge sys_clk);
  endtask
  ////////////////////////
  always @(posedge sys_clk)
    rd_d <= reg_rd;
  always @(negedge sys_clk)
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
  initial
  begin
    void'($urandom(32'hD4C5));
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    acc(0, OFS_MASK_CLR, '0);
    repeat (20)
    begin
      acc(1, OFS_MASK_SET, $urandom());
      acc(0, OFS_MASK_CLR, m);
      acc(1, OFS_MASK_CLR, $urandom());
      acc(0, OFS_MASK_SET, m);
    end
    acc(1, 8'h40, '1);
    acc(0, 8'h40, '0);
    for (int i = 0; i < 31; i++)
      if (MASK_IMPL[i] && i != BIT_ISO_RX && i != BIT_ISO_TX)
      begin
        b = 32'h1 << i;
        acc(1, OFS_MASK_CLR, '1);
        acc(1, OFS_MASK_SET, b | 32'h8000_0000);
        irq_is(~b, 1'b0);
        irq_is(b, 1'b1);
        irq_is(b, 1'b1);
        acc(1, OFS_MASK_CLR, 32'h8000_0000);
        irq_is(b, 1'b0);
      end
    acc(1, OFS_ISO_TX_MASK_SET, 32'h01);
    acc(1, OFS_ISO_RX_MASK_SET, 32'h80);
    acc(1, OFS_MASK_SET, 32'h8000_00C0);
    iso_tx_ctx_event <= 8'h01;
    irq_is('0, 1'b1);
    iso_tx_ctx_event <= 8'hFE;
    irq_is('0, 1'b0);
    iso_rx_ctx_event <= 8'h80;
    irq_is('0, 1'b1);
    acc(0, OFS_ISO_TX_MASK_CLR, 32'h0000_0001);
    acc(0, OFS_ISO_RX_MASK_SET, 32'h0000_0080);
    acc(0, OFS_PENDING, 32'h0000_0080);
    // A second reset in mid-run must drop every enable and the interrupt.
    acc(1, OFS_MASK_SET, '1);
    event_bits <= '1;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    m = '0;
    acc(0, OFS_MASK_SET, m);
    irq_is('1, 1'b0);
    stop_test();
  end
endmodule
